// [verilog/ssp_pkg.sv]
/*
  ssp_pkg: shared types and constants for the serial port block.
  Assumes one system clock of 50 MHz and a synchronous active-low reset.
*/
package ssp_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;

  // rate select codes
  localparam logic [1:0] RATE_DIV2 = 2'h0;
  localparam logic [1:0] RATE_DIV4 = 2'h1;
  localparam logic [1:0] RATE_DIV16 = 2'h2;
  localparam logic [1:0] RATE_DIV32 = 2'h3;

  // half of each divisor, in system clocks
  localparam logic [3:0] HALF_DIV2 = 4'h1;
  localparam logic [3:0] HALF_DIV4 = 4'h2;
  localparam logic [3:0] HALF_DIV16 = 4'h8;
  localparam logic [3:0] HALF_DIV32 = 4'h0;  // wraps: sixteen clocks

  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // indices of the synchronised pins
  localparam int unsigned SYN_SS = 0;
  localparam int unsigned SYN_SCK = 1;
  localparam int unsigned SYN_MISO = 2;
  localparam int unsigned SYN_MOSI = 3;
  localparam logic [3:0] SYN_RESET = 4'hF;  // all lines idle high

  // serial control register contents
  typedef struct packed {
    logic irq_enable;
    logic system_enable;
    logic master_select;
    logic clock_polarity;
    logic clock_phase;
    logic [1:0] rate_select;  // {rate_select_high, rate_select_low}
  } ssp_ctrl_t;

  localparam ssp_ctrl_t CTRL_RESET = '0;

  // serial status register contents
  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
  } ssp_status_t;

  // pin drive: level and enable for each shared line
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } ssp_pins_t;

endpackage

// [verilog/ssp_port.sv]
/*
  ssp_port: byte-wide full-duplex serial port, master or slave.
  Assumes: pins arrive asynchronously and are synchronised here; the
  register strobes are one-cycle pulses from logic on clk_sys; the
  surrounding pad logic resolves each line from its output enable.
*/
`timescale 1ns/1ps

module ssp_port
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ctrl_wr,
  input wire ssp_pkg::ssp_ctrl_t ctrl_wdata,
  output ssp_pkg::ssp_ctrl_t ctrl_rdata,
  input wire logic status_rd,
  output ssp_pkg::ssp_status_t status,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata,
  output logic irq,
  input wire logic ss_n_i,
  input wire logic sck_i,
  input wire logic miso_i,
  input wire logic mosi_i,
  output ssp_pkg::ssp_pins_t pins
);
  import ssp_pkg::*;

  function automatic logic [3:0] half_period(input logic [1:0] rate);
    if (rate == RATE_DIV2)
      half_period = HALF_DIV2;
    else if (rate == RATE_DIV4)
      half_period = HALF_DIV4;
    else if (rate == RATE_DIV16)
      half_period = HALF_DIV16;
    else
      half_period = HALF_DIV32;
  endfunction

  ssp_ctrl_t ctrl_q;
  ssp_status_t stat_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic sck_prev_q;
  logic [7:0] shift_q;
  logic [7:0] rbuf_q;
  logic out_q;
  logic in_bit_q;
  logic [2:0] bits_q;
  logic half_q;       // between leading and trailing edge
  logic run_q;
  logic act_q;        // master clock at its active level
  logic [3:0] div_q;
  logic done_arm_q;
  logic write_collision_flag_arm_q;
  logic mode_fault_flag_arm_q;

  // decode
  wire en = ctrl_q.system_enable;
  wire is_master = en && ctrl_q.master_select;
  wire is_slave = en && !ctrl_q.master_select;
  wire ss_low = !sync2_q[SYN_SS];
  wire sck_act = sync2_q[SYN_SCK] ^ ctrl_q.clock_polarity;
  wire sck_act_prev = sck_prev_q ^ ctrl_q.clock_polarity;
  wire selected = is_slave && ss_low;
  wire in_bit = is_master ? sync2_q[SYN_MISO] : sync2_q[SYN_MOSI];
  wire m_tick = run_q && (div_q == half_period(ctrl_q.rate_select) - 4'h1);
  wire m_lead = is_master && m_tick && !act_q;
  wire m_trail = is_master && m_tick && act_q;
  // select gates the slave clock in both phases
  wire s_lead = selected && sck_act && !sck_act_prev;
  wire s_trail = selected && !sck_act && sck_act_prev && half_q;
  wire lead = m_lead || s_lead;
  wire trail = m_trail || s_trail;
  wire done_evt = trail && (bits_q == LAST_BIT);
  // a phase 0 slave is busy for all the time it is selected
  wire s_busy = selected && (!ctrl_q.clock_phase || half_q
                || bits_q != FIRST_BIT);
  wire busy = run_q || s_busy;
  wire inhibit = stat_q.transfer_done_flag && !done_arm_q;
  wire wr_ok = data_wr && !busy && !inhibit;
  wire wr_coll = data_wr && busy;
  wire mode_fault_flag_evt = is_master && ss_low;
  wire data_acc = data_wr || data_rd;
  wire [7:0] shift_in = {shift_q[6:0],
                         ctrl_q.clock_phase ? in_bit : in_bit_q};

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      sync1_q <= SYN_RESET;
      sync2_q <= SYN_RESET;
      sck_prev_q <= SYN_RESET[SYN_SCK];
    end
    else
    begin
      sync1_q <= {mosi_i, miso_i, sck_i, ss_n_i};
      sync2_q <= sync1_q;
      sck_prev_q <= sync2_q[SYN_SCK];
    end
  end

  // control register; mode fault drops enable and master
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      ctrl_q <= CTRL_RESET;
    else if (mode_fault_flag_evt)
    begin
      ctrl_q.system_enable <= 1'b0;
      ctrl_q.master_select <= 1'b0;
    end
    else if (ctrl_wr)
      ctrl_q <= ctrl_wdata;
  end

  // master bit-rate divider; rate ignored in slave mode
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || !run_q || m_tick)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end

  // master sequencer: idle clock at polarity, eight cycles per write
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || !is_master)
    begin
      run_q <= 1'b0;
      act_q <= 1'b0;
    end
    else if (wr_ok)
      run_q <= 1'b1;
    else if (m_tick)
    begin
      act_q <= !act_q;
      if (done_evt)
        run_q <= 1'b0;
    end
  end

  // shared shift engine, msb first, one register both ways
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      shift_q <= DATA_RESET;
      out_q <= 1'b0;
      in_bit_q <= 1'b0;
      bits_q <= FIRST_BIT;
      half_q <= 1'b0;
    end
    else if (wr_ok)
    begin
      shift_q <= data_wdata;
      out_q <= data_wdata[7];
      bits_q <= FIRST_BIT;
      half_q <= 1'b0;
    end
    else if (is_slave && !ss_low)
    begin
      // deselect aborts a partial byte and realigns the slave
      bits_q <= FIRST_BIT;
      half_q <= 1'b0;
      out_q <= shift_q[7];
    end
    else if (lead)
    begin
      half_q <= 1'b1;
      if (ctrl_q.clock_phase)
        out_q <= shift_q[7];
      else
        in_bit_q <= in_bit;
    end
    else if (trail)
    begin
      half_q <= 1'b0;
      shift_q <= shift_in;
      bits_q <= bits_q + 3'h1;
      if (!ctrl_q.clock_phase)
        out_q <= shift_q[6];
    end
    else if (!busy)
      out_q <= shift_q[7];
  end

  // read buffer takes the byte unless it would overrun
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      rbuf_q <= DATA_RESET;
    else if (done_evt && !stat_q.transfer_done_flag)
      rbuf_q <= shift_in;
  end

  // status flags: set wins over clear
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      stat_q <= '0;
      done_arm_q <= 1'b0;
      write_collision_flag_arm_q <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end
    else
    begin
      if (done_evt)
        stat_q.transfer_done_flag <= 1'b1;
      else if (done_arm_q && data_acc)
        stat_q.transfer_done_flag <= 1'b0;
      if (wr_coll)
        stat_q.write_collision_flag <= 1'b1;
      else if (write_collision_flag_arm_q && data_acc)
        stat_q.write_collision_flag <= 1'b0;
      if (mode_fault_flag_evt)
        stat_q.mode_fault_flag <= 1'b1;
      else if (mode_fault_flag_arm_q && ctrl_wr)
        stat_q.mode_fault_flag <= 1'b0;
      if (done_evt || data_acc)
        done_arm_q <= 1'b0;
      else if (status_rd && stat_q.transfer_done_flag)
        done_arm_q <= 1'b1;
      if (wr_coll || data_acc)
        write_collision_flag_arm_q <= 1'b0;
      else if (status_rd && stat_q.write_collision_flag)
        write_collision_flag_arm_q <= 1'b1;
      if (mode_fault_flag_evt || ctrl_wr)
        mode_fault_flag_arm_q <= 1'b0;
      else if (status_rd && stat_q.mode_fault_flag)
        mode_fault_flag_arm_q <= 1'b1;
    end
  end

  // pin directions follow mode while enabled
  // one driver for the whole pin struct
  assign pins = '{
    sck_o: act_q ^ ctrl_q.clock_polarity,
    sck_oe: is_master,
    mosi_o: out_q,
    mosi_oe: is_master,
    miso_o: out_q,
    miso_oe: selected
  };

  assign ctrl_rdata = ctrl_q;
  assign status = stat_q;
  assign data_rdata = rbuf_q;
  assign irq = ctrl_q.irq_enable
               && (stat_q.transfer_done_flag || stat_q.mode_fault_flag);

  // master slowest rate: 15 quiet cycles between ticks
  property p_rate;
    @(posedge clk_sys) disable iff (!rstn)
    m_tick && ctrl_q.rate_select == RATE_DIV32 && !done_evt
    |=> !m_tick [*8] ##1 !m_tick [*7] ##1 m_tick;
  endproperty
  a_rate: assert property (p_rate)
    else $error("slow master clock half period wrong");

  property p_fastest;
    @(posedge clk_sys) disable iff (!rstn)
    m_lead && ctrl_q.rate_select == RATE_DIV2 |=> m_trail;
  endproperty
  a_fastest: assert property (p_fastest)
    else $error("fastest master clock not half system clock");

  property p_mode_fault_flag;
    @(posedge clk_sys) disable iff (!rstn)
    mode_fault_flag_evt |=> stat_q.mode_fault_flag && !en && !pins.sck_oe;
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag)
    else $error("mode fault did not drop to slave");

  property p_sck_idle;
    @(posedge clk_sys) disable iff (!rstn)
    is_master && !run_q |-> pins.sck_o == ctrl_q.clock_polarity;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("master clock not at idle level");

  property p_miso_float;
    @(posedge clk_sys) disable iff (!rstn)
    sync2_q[SYN_SS] || !en || ctrl_q.master_select |-> !pins.miso_oe;
  endproperty
  a_miso_float: assert property (p_miso_float)
    else $error("data-in line driven while not selected");

  property p_master_pins;
    @(posedge clk_sys) disable iff (!rstn)
    is_master |-> pins.mosi_oe && pins.sck_oe && !pins.miso_oe;
  endproperty
  a_master_pins: assert property (p_master_pins)
    else $error("master pin directions wrong");

  property p_write_collision_flag;
    @(posedge clk_sys) disable iff (!rstn)
    wr_coll && !trail |=> stat_q.write_collision_flag && $stable(shift_q);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag)
    else $error("collided write disturbed transfer");

  property p_done;
    @(posedge clk_sys) disable iff (!rstn)
    done_evt |=> stat_q.transfer_done_flag && bits_q == FIRST_BIT;
  endproperty
  a_done: assert property (p_done)
    else $error("done flag not set after eighth bit");

  property p_overrun;
    @(posedge clk_sys) disable iff (!rstn)
    done_evt && stat_q.transfer_done_flag |=> $stable(rbuf_q);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun byte reached the read buffer");

  property p_inhibit;
    @(posedge clk_sys) disable iff (!rstn)
    data_wr && inhibit && !busy |=> $stable(shift_q) && !run_q;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("write accepted before status read");

endmodule // ssp_port

// [verification/ssp_far_dev.sv]
/*
  ssp_far_dev: behavioural far-side serial slave for the port bench.
  Assumes the bench sets tx_byte and the mode before selecting it.
*/
`timescale 1ns/1ps

module ssp_far_dev
(
  input wire logic sel_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] sh_q
);
  logic drv = 1'b0;
  logic in_bit = 1'b0;

  // released line shows the inverse, never a stale copy
  assign miso = sel_n ? ~drv : drv;

  always @(negedge sel_n)
  begin
    sh_q = tx_byte;
    drv = tx_byte[7];
  end

  always @(sck)
  begin
    if (!sel_n && sck !== clock_polarity_bit && clock_phase_bit)
      drv = sh_q[7];
    else if (!sel_n && sck !== clock_polarity_bit)
      in_bit = mosi;
    else if (!sel_n && clock_phase_bit)
      sh_q = {sh_q[6:0], mosi};
    else if (!sel_n)
    begin
      sh_q = {sh_q[6:0], in_bit};
      drv = sh_q[7];
    end
  end
endmodule // ssp_far_dev

// [verification/ssp_port_test.sv]
/*
  ssp_port_test: self-checking bench for the serial port.
  Assumes the far-side model above and no other driver on the lines.
*/
`timescale 1ns/1ps

module ssp_port_test;
  import ssp_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ctrl_wr = 1'b0;
  ssp_ctrl_t ctrl_wdata = '0;
  ssp_ctrl_t ctrl_rdata;
  logic status_rd = 1'b0;
  ssp_status_t status;
  logic data_wr = 1'b0;
  logic data_rd = 1'b0;
  logic [7:0] data_wdata = 8'h00;
  logic [7:0] data_rdata;
  logic irq;
  logic tb_ss_n = 1'b1;
  logic tb_sck = 1'b0;
  logic tb_mosi = 1'b0;
  logic far_sel_n = 1'b1;
  logic [7:0] far_tx = 8'h00;
  logic [7:0] far_sh;
  logic far_miso;
  ssp_pins_t pins;
  wire sck_w = pins.sck_oe ? pins.sck_o : tb_sck;
  wire mosi_w = pins.mosi_oe ? pins.mosi_o : tb_mosi;
  wire miso_w = pins.miso_oe ? pins.miso_o : far_miso;
  int num_errors = 0;
  int num_checks = 0;

  always #10 clk_sys = ~clk_sys;

  ssp_port i_dut (.clk_sys(clk_sys), .rstn(rstn), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .status_rd(status_rd), .status(status), .data_wr(data_wr),
    .data_rd(data_rd), .data_wdata(data_wdata), .data_rdata(data_rdata),
    .irq(irq), .ss_n_i(tb_ss_n), .sck_i(sck_w), .miso_i(miso_w),
    .mosi_i(mosi_w), .pins(pins));

  ssp_far_dev i_far (.sel_n(far_sel_n), .sck(pins.sck_o),
    .mosi(pins.mosi_o), .clock_polarity_bit(ctrl_rdata.clock_polarity),
    .clock_phase_bit(ctrl_rdata.clock_phase), .tx_byte(far_tx), .miso(far_miso),
    .sh_q(far_sh));

  task automatic tick();
    @(posedge clk_sys);
    #2;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic strobe(input logic s_rd, input logic d_rd, input logic d_wr);
    {status_rd, data_rd, data_wr} = {s_rd, d_rd, d_wr};
    tick();
    {status_rd, data_rd, data_wr} = 3'h0;
    tick();
  endtask

  task automatic set_ctrl(input ssp_ctrl_t c);
    ctrl_wdata = c;
    ctrl_wr = 1'b1;
    tick();
    ctrl_wr = 1'b0;
    tick();
  endtask

  function automatic int exp_half(input logic [1:0] r);
    case (r)
      2'h0: return 1;
      2'h1: return 2;
      2'h2: return 8;
      default: return 16;
    endcase
  endfunction

  // second write lands mid-transfer to provoke a collision
  task automatic master_xfer(input logic [7:0] b, output int tg,
    output int gap);
    logic prev;
    int t1;
    tg = 0;
    gap = 0;
    t1 = 0;
    prev = pins.sck_o;
    data_wdata = b;
    // one edge of write only, so the first clock edge is watched
    data_wr = 1'b1;
    tick();
    for (int i = 0; i < 1200 && status.transfer_done_flag !== 1'b1; i++)
    begin
      data_wr = (i == 4);
      data_wdata = (i == 4) ? ~b : b;
      tick();
      if (pins.sck_o !== prev)
      begin
        tg++;
        if (tg == 1)
          t1 = i;
        if (tg == 2)
          gap = i - t1;
        prev = pins.sck_o;
      end
    end
    data_wr = 1'b0;
    if (status.transfer_done_flag !== 1'b1)
    begin
      num_errors++;
      report_and_stop();
    end
  endtask

  task automatic slave_xfer(input logic [7:0] b, input logic pol,
    input logic ph, output logic [7:0] rx);
    rx = 8'h00;
    tb_ss_n = 1'b0;
    repeat (8) tick();
    check("miso_oe sel", 8'(pins.miso_oe), 8'h01);
    for (int i = 7; i >= 0; i--)
    begin
      if (ph)
        tb_sck = ~pol;
      tb_mosi = b[i];
      repeat (8) tick();
      rx = {rx[6:0], pins.miso_o};
      tb_sck = ph ? pol : ~pol;
      repeat (8) tick();
      if (!ph)
        tb_sck = pol;
    end
    repeat (8) tick();
    tb_ss_n = 1'b1;
    repeat (4) tick();
  endtask

  initial
  begin
    ssp_ctrl_t c;
    logic [7:0] b;
    logic [7:0] rx;
    logic [3:0] md;
    int tg;
    int gap;
    void'($urandom(32'hA145));
    repeat (6) tick();
    rstn = 1'b1;
    tick();
    check("ctrl reset", 8'(ctrl_rdata), 8'h00);
    check("status reset", 8'(status), 8'h00);
    check("oe reset", 8'({pins.sck_oe, pins.mosi_oe, pins.miso_oe}), 8'h00);
    for (int m = 0; m < 16; m++)
    begin
      md = 4'(m);
      c = '0;
      {c.irq_enable, c.system_enable, c.master_select} = 3'h7;
      {c.clock_polarity, c.clock_phase, c.rate_select} = md;
      set_ctrl(c);
      check("ctrl", 8'(ctrl_rdata), 8'(c));
      check("master oe", 8'({pins.sck_oe, pins.mosi_oe, pins.miso_oe}),
        8'h06);
      check("sck idle", 8'(pins.sck_o), 8'(md[3]));
      far_tx = 8'($urandom);
      b = 8'($urandom);
      far_sel_n = 1'b0;
      master_xfer(b, tg, gap);
      far_sel_n = 1'b1;
      check("sck edges", 8'(tg), 8'h10);
      check("half period", 8'(gap), 8'(exp_half(md[1:0])));
      check("far rx", far_sh, b);
      check("status", 8'(status), 8'h06);
      check("irq", 8'(irq), 8'h01);
      if (md[1])
        check("rbuf", data_rdata, far_tx);
      data_wdata = ~b;
      strobe(1'b0, 1'b0, 1'b1);
      tg = 0;
      repeat (40)
      begin
        tick();
        if (pins.sck_o !== md[3])
          tg++;
      end
      check("inhibited", 8'(tg), 8'h00);
      strobe(1'b1, 1'b0, 1'b0);
      strobe(1'b0, 1'b1, 1'b0);
      check("cleared", 8'(status), 8'h00);
    end
    tb_ss_n = 1'b0;
    repeat (6) tick();
    check("fault", 8'(status.mode_fault_flag), 8'h01);
    check("fault ctrl", 8'({ctrl_rdata.system_enable,
      ctrl_rdata.master_select, irq}), 8'h01);
    tb_ss_n = 1'b1;
    strobe(1'b1, 1'b0, 1'b0);
    set_ctrl('0);
    check("fault clr", 8'(status.mode_fault_flag), 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      md = 4'(m);
      c = '0;
      c.system_enable = 1'b1;
      {c.clock_polarity, c.clock_phase} = md[1:0];
      c.rate_select = 2'($urandom);
      tb_sck = md[1];
      set_ctrl(c);
      check("slave oe", 8'({pins.sck_oe, pins.mosi_oe, pins.miso_oe}),
        8'h00);
      b = 8'($urandom);
      data_wdata = b;
      strobe(1'b0, 1'b0, 1'b1);
      far_tx = 8'($urandom);
      slave_xfer(far_tx, md[1], md[0], rx);
      check("slave tx", rx, b);
      check("slave rbuf", data_rdata, far_tx);
      check("slave done", 8'(status), 8'h04);
      check("miso_oe off", 8'(pins.miso_oe), 8'h00);
      // second byte with done still set: buffer keeps the first
      if (md[0])
      begin
        slave_xfer(~far_tx, md[1], md[0], rx);
        check("overrun", data_rdata, far_tx);
        check("resend", rx, far_tx);
      end
      strobe(1'b1, 1'b0, 1'b0);
      strobe(1'b0, 1'b1, 1'b0);
    end
    report_and_stop();
  end
endmodule // ssp_port_test
